// file: core/gpio_cfg_pkg.sv
// Purpose: Shared constants and encodings for the GPIO port configuration block
// Assumes: Eight pins, one system clock
// Notes: Encodings are local codes chosen for this port
package gpio_cfg_pkg;
    localparam int PIN_COUNT = 8;
    localparam int PIN_IDX_W = 3;

    // Direction and control mode
    typedef enum logic [1:0] {
        mode_sw_input        = 2'h0,
        mode_sw_output       = 2'h1,
        mode_peripheral_ctrl = 2'h2
    } dir_mode_t;

    // Interrupt trigger types
    typedef enum logic [2:0] {
        trig_falling_edge = 3'h0,
        trig_rising_edge  = 3'h1,
        trig_both_edges   = 3'h2,
        trig_low_level    = 3'h3,
        trig_high_level   = 3'h4
    } trig_t;

    // Drive strength
    typedef enum logic [1:0] {
        drive_lowest         = 2'h0,
        drive_middle         = 2'h1,
        drive_highest        = 2'h2,
        drive_highest_slewed = 2'h3
    } drive_t;

    // Pad type
    typedef enum logic [2:0] {
        pad_push_pull           = 3'h0,
        pad_push_pull_pullup    = 3'h1,
        pad_push_pull_pulldown  = 3'h2,
        pad_open_drain          = 3'h3,
        pad_open_drain_pullup   = 3'h4,
        pad_open_drain_pulldown = 3'h5,
        pad_analog              = 3'h6
    } pad_t;

    // Reset values
    localparam dir_mode_t MODE_RESET = mode_sw_input;
    localparam trig_t TRIG_RESET = trig_falling_edge;
    localparam drive_t DRIVE_RESET = drive_lowest;
    localparam pad_t PAD_RESET = pad_push_pull;
endpackage : gpio_cfg_pkg

// file: core/gpio_edge_detect.sv
// Purpose: One pin's trigger detector, edge or level
// Assumes: pin_sync already synchronised to ref_clk
// Notes: Event is a one-cycle pulse for edges, a level for level triggers
`timescale 1ns/1ps
module gpio_edge_detect
    import gpio_cfg_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Pin and setting
    input wire logic pin_sync,
    input wire logic [2:0] trig_sel,
    // Result
    output logic event_reg
);
    logic prev_reg;
    logic prev_next;
    logic event_next;

    // Compare current and previous sample per trigger type
    always_comb begin
        prev_next = pin_sync;
        case (trig_t'(trig_sel))
            trig_falling_edge: event_next = prev_reg & ~pin_sync;
            trig_rising_edge: event_next = ~prev_reg & pin_sync;
            trig_both_edges: event_next = prev_reg ^ pin_sync;
            trig_low_level: event_next = ~pin_sync;
            trig_high_level: event_next = pin_sync;
            default: event_next = 1'b0;
        endcase
    end

    // Register history and event
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            prev_reg <= 1'b0;
            event_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            event_reg <= event_next;
        end
    end
endmodule : gpio_edge_detect

// file: core/gpio_port_cfg.sv
// Purpose: Per-pin mode, trigger and pad configuration with readback and detection
// Assumes: Single ref_clk at 40 MHz, synchronous active-low nrst
// Notes: Writes are masked by pin_select_mask; configuration reads select a single pin index
// Notes on behaviour
// - Each pin independently set to software input, software output, or peripheral
// - Mode of one selected pin reads back in the same encoding
// - Writes affect only pins whose mask bit is set; others keep settings
// - Trigger supports falling, rising, both edges, low level, high level
// - Trigger type of one selected pin reads back in same encoding
// - Drive strength per pin: 2, 4, 8 mA, 8 mA slewed; sent to pad
// - Pad type per pin: push-pull or open-drain with pulls, or analog
// - Pad setting stored as written even for input pins
// - Drive and pad type read back for any pin, inputs included
// - Reset: software input, lowest drive, no pull, push-pull, not peripheral
// - Up to eight pins, each with its own full configuration
// - Data access masked per pin; read zeroes unselected, write simultaneous
`timescale 1ns/1ps
module gpio_port_cfg
    import gpio_cfg_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Configuration write
    input wire logic [7:0] pin_select_mask,
    input wire logic mode_wr,
    input wire logic [1:0] mode_wdata,
    input wire logic trig_wr,
    input wire logic [2:0] trig_wdata,
    input wire logic pad_wr,
    input wire logic [1:0] drive_wdata,
    input wire logic [2:0] pad_wdata,
    // Configuration readback
    input wire logic [2:0] pin_index,
    output logic [1:0] mode_rdata_reg,
    output logic [2:0] trig_rdata_reg,
    output logic [1:0] drive_rdata_reg,
    output logic [2:0] pad_rdata_reg,
    // Data access
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    output logic [7:0] data_rdata_reg,
    // Pins and peripheral
    input wire logic [7:0] pin_in,
    input wire logic [7:0] periph_out,
    input wire logic [7:0] periph_oe,
    output logic [7:0] pin_out_reg,
    output logic [7:0] pin_oe_n_reg,
    output logic [15:0] pad_drive_reg,
    output logic [23:0] pad_type_reg,
    output logic [7:0] pin_sync_reg,
    // Detection
    output logic [7:0] trig_event_reg
);
    // Per-pin storage, one entry per pin
    // Arrays are indexed by pin number, so pin_index reads one entry directly
    logic [1:0] mode_reg [PIN_COUNT];
    logic [1:0] mode_next [PIN_COUNT];
    logic [2:0] trig_reg [PIN_COUNT];
    logic [2:0] trig_next [PIN_COUNT];
    logic [1:0] drive_reg [PIN_COUNT];
    logic [1:0] drive_next [PIN_COUNT];
    logic [2:0] pad_reg [PIN_COUNT];
    logic [2:0] pad_next [PIN_COUNT];
    logic [7:0] data_reg;
    logic [7:0] data_next;
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] sync3_reg;
    logic [7:0] stable_next;
    logic [7:0] out_next;
    logic [7:0] oe_n_next;
    logic [15:0] drive_bus_next;
    logic [23:0] type_bus_next;
    logic [7:0] rdata_next;
    logic [7:0] event_w;

    // Pad is actively driven only in push-pull, or open-drain when pulling low
    // Analog pads never drive: the enable stays off, though pin_out_reg still follows its source
    function automatic logic drives_pad(input logic [2:0] pad, input logic level);
        if (pad == pad_analog) begin
            drives_pad = 1'b0;
        end else if (pad >= pad_open_drain) begin
            drives_pad = ~level;
        end else begin
            drives_pad = 1'b1;
        end
    endfunction : drives_pad

    // Masked update of configuration; only selected pins change
    // Unused codes are stored as written; the consumers treat them as harmless
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            mode_next[i] = mode_reg[i];
            trig_next[i] = trig_reg[i];
            drive_next[i] = drive_reg[i];
            pad_next[i] = pad_reg[i];
            if (pin_select_mask[i]) begin
                if (mode_wr) begin
                    mode_next[i] = mode_wdata;
                end
                if (trig_wr) begin
                    trig_next[i] = trig_wdata;
                end
                if (pad_wr) begin
                    drive_next[i] = drive_wdata;
                    pad_next[i] = pad_wdata;
                end
            end
        end
    end

    // Configuration state; takes effect on the edge after the write strobe
    // Reset clears every pin at once, whatever the mask holds
    // Falling-edge reset trigger and low synchronised pins mean no false event after reset
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (!nrst) begin
                mode_reg[i] <= MODE_RESET;
                trig_reg[i] <= TRIG_RESET;
                drive_reg[i] <= DRIVE_RESET;
                pad_reg[i] <= PAD_RESET;
            end else begin
                mode_reg[i] <= mode_next[i];
                trig_reg[i] <= trig_next[i];
                drive_reg[i] <= drive_next[i];
                pad_reg[i] <= pad_next[i];
            end
        end
    end

    // Data register: masked write changes all selected pins at once
    // Unselected bits keep their value, so one write cannot disturb other pins
    always_comb begin
        data_next = data_wr ? ((data_reg & ~pin_select_mask) | (data_wdata & pin_select_mask)) : data_reg;
    end

    // Pin input synchroniser; a change counts once stages two and three agree
    // A one-cycle glitch at stage two never reaches the detectors
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            stable_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : pin_sync_reg[i];
        end
    end

    // Pad drive and bus outputs from current configuration
    // Inputs and the unused mode code leave the pad undriven
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (mode_reg[i] == mode_peripheral_ctrl) begin
                out_next[i] = periph_out[i];
                oe_n_next[i] = ~(periph_oe[i] & drives_pad(pad_reg[i], periph_out[i]));
            end else if (mode_reg[i] == mode_sw_output) begin
                out_next[i] = data_reg[i];
                oe_n_next[i] = ~drives_pad(pad_reg[i], data_reg[i]);
            end else begin
                out_next[i] = 1'b0; // Inputs never drive; only pulls act
                oe_n_next[i] = 1'b1;
            end
            drive_bus_next[2*i +: 2] = drive_reg[i];
            type_bus_next[3*i +: 3] = pad_reg[i];
        end
        // Read shows selected pins only, others zero
        // The read value then stands until the next read strobe
        rdata_next = data_rd ? (pin_sync_reg & pin_select_mask) : data_rdata_reg;
    end

    // Output and synchroniser registers
    // Readback is registered, so it shows the pin chosen one edge earlier
    // Trade-off: one cycle of latency buys outputs straight from flip-flops
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            data_reg <= 8'h00;
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
            sync3_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
            pin_out_reg <= 8'h00;
            pin_oe_n_reg <= 8'hFF;
            pad_drive_reg <= 16'h0000;
            pad_type_reg <= 24'h000000;
            data_rdata_reg <= 8'h00;
            mode_rdata_reg <= 2'h0;
            trig_rdata_reg <= 3'h0;
            drive_rdata_reg <= 2'h0;
            pad_rdata_reg <= 3'h0;
            trig_event_reg <= 8'h00;
        end else begin
            data_reg <= data_next;
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_sync_reg <= stable_next;
            pin_out_reg <= out_next;
            pin_oe_n_reg <= oe_n_next;
            pad_drive_reg <= drive_bus_next;
            pad_type_reg <= type_bus_next;
            data_rdata_reg <= rdata_next;
            mode_rdata_reg <= mode_reg[pin_index];
            trig_rdata_reg <= trig_reg[pin_index];
            drive_rdata_reg <= drive_reg[pin_index];
            pad_rdata_reg <= pad_reg[pin_index];
            trig_event_reg <= event_w;
        end
    end

    // One detector per pin; relies on inputs held steady while trigger changes
    // Each detector sees the filtered level, never the raw pin
    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_det
        gpio_edge_detect u_det (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .pin_sync(pin_sync_reg[g]),
            .trig_sel(trig_reg[g]),
            .event_reg(event_w[g])
        );
    end
endmodule : gpio_port_cfg

// file: bench/gpio_port_cfg_chk.sv
// Purpose: Port-level assertions for gpio_port_cfg
// Assumes: One clock, synchronous active-low nrst
// Notes: Readback lags a write by two edges, index held
`timescale 1ns/1ps
module gpio_port_cfg_chk
    import gpio_cfg_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Write side
    input wire logic [7:0] pin_select_mask,
    input wire logic mode_wr,
    input wire logic [1:0] mode_wdata,
    input wire logic trig_wr,
    input wire logic [2:0] trig_wdata,
    input wire logic pad_wr,
    input wire logic [1:0] drive_wdata,
    input wire logic [2:0] pad_wdata,
    input wire logic data_rd,
    // Read side
    input wire logic [2:0] pin_index,
    input wire logic [1:0] mode_rdata_reg,
    input wire logic [2:0] trig_rdata_reg,
    input wire logic [1:0] drive_rdata_reg,
    input wire logic [2:0] pad_rdata_reg,
    input wire logic [7:0] data_rdata_reg,
    input wire logic [7:0] pin_oe_n_reg,
    input wire logic [15:0] pad_drive_reg,
    input wire logic [23:0] pad_type_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // Selected pin shows the written code two edges later
    a_mode_read: assert property (mode_wr && pin_select_mask[pin_index] ##1 $stable(pin_index)
        |=> mode_rdata_reg == $past(mode_wdata, 2)) else $error("mode readback wrong");
    a_trig_read: assert property (trig_wr && pin_select_mask[pin_index] ##1 $stable(pin_index)
        |=> trig_rdata_reg == $past(trig_wdata, 2)) else $error("trigger readback wrong");
    a_drive_read: assert property (pad_wr && pin_select_mask[pin_index] ##1 $stable(pin_index)
        |=> drive_rdata_reg == $past(drive_wdata, 2)) else $error("drive readback wrong");
    a_pad_read: assert property (pad_wr && pin_select_mask[pin_index] ##1 $stable(pin_index)
        |=> pad_rdata_reg == $past(pad_wdata, 2)) else $error("pad readback wrong");
    // An unselected pin must not move
    a_unsel_keep: assert property (mode_wr && !pin_select_mask[pin_index] ##1 $stable(pin_index)
        |=> $stable(mode_rdata_reg)) else $error("unselected pin changed");
    // Reset checked while reset is low, so it carries its own disable
    a_reset_cfg: assert property (disable iff (1'b0) !nrst |=> pin_oe_n_reg == 8'hFF
        && pad_drive_reg == 16'h0000 && pad_type_reg == 24'h000000) else $error("reset state wrong");
    a_data_mask: assert property (data_rd |=> (data_rdata_reg & ~$past(pin_select_mask)) == 8'h00)
        else $error("unselected data bit set");
    a_data_hold: assert property (!data_rd |=> $stable(data_rdata_reg))
        else $error("data read value moved");

    c_mode: cover property (mode_wr && pin_select_mask[pin_index]);
    c_pad: cover property (pad_wr && pin_select_mask[pin_index]);
    c_data: cover property (data_rd);
endmodule : gpio_port_cfg_chk

bind gpio_port_cfg gpio_port_cfg_chk i_gpio_port_cfg_chk (.*);

// file: bench/gpio_port_cfg_tb.sv
// Purpose: Directed bench for gpio_port_cfg
// Assumes: Inputs change on falling edges
// Notes: Peripheral drives pins 0 and 3 high from the mode test on
`timescale 1ns/1ps
module gpio_port_cfg_tb;
    import gpio_cfg_pkg::*;
    logic ref_clk, nrst, mode_wr, trig_wr, pad_wr, data_rd, data_wr;
    logic [7:0] pin_select_mask, data_wdata, pin_in, periph_out, periph_oe;
    logic [7:0] data_rdata_reg, pin_out_reg, pin_oe_n_reg, pin_sync_reg, trig_event_reg;
    logic [1:0] mode_wdata, drive_wdata, mode_rdata_reg, drive_rdata_reg;
    logic [2:0] trig_wdata, pad_wdata, pin_index, trig_rdata_reg, pad_rdata_reg;
    logic [15:0] pad_drive_reg;
    logic [23:0] pad_type_reg;
    int num_errors = 0;
    int comparisons = 0;

    gpio_port_cfg i_gpio_port_cfg (.*);

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // One strobe cycle; k picks mode, trigger or pad
    task automatic cfg_wr(input int k, input logic [7:0] m, input logic [2:0] v, input logic [1:0] d);
        @(negedge ref_clk);
        pin_select_mask = m;
        {mode_wdata, trig_wdata, pad_wdata, drive_wdata} = {v[1:0], v, v, d};
        {mode_wr, trig_wr, pad_wr} = {k == 0, k == 1, k == 2};
        @(negedge ref_clk);
        {mode_wr, trig_wr, pad_wr} = 3'h0;
    endtask : cfg_wr

    // Readback is registered, so hold the index one cycle
    task automatic rd(input logic [2:0] i);
        @(negedge ref_clk);
        pin_index = i;
        @(negedge ref_clk);
    endtask : rd

    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0]);
            check("reset cfg", {mode_rdata_reg, trig_rdata_reg, drive_rdata_reg, pad_rdata_reg}, 0);
        end
        check("reset pad", {pin_oe_n_reg, pad_drive_reg}, 24'hFF0000);
        check("reset type", pad_type_reg, 24'h000000);
        $display("reset test done");
    endtask : t_reset

    // Index 3 is left selected so the next write hits the watched pin
    task automatic t_mode();
        periph_out = 8'h09;
        periph_oe = 8'h09;
        for (int m = 0; m < 3; m++) begin
            cfg_wr(0, 8'h09, m[2:0], 2'h0);
            rd(3'h1);
            check("mode unsel", mode_rdata_reg, 0);
            rd(3'h3);
            check("mode", mode_rdata_reg, m);
            check("oe", pin_oe_n_reg[0], m == 0);
            check("out", pin_out_reg[0], m == 2);
        end
        $display("mode test done");
    endtask : t_mode

    // Pins stay still while triggers change
    task automatic t_trig();
        for (int t = 0; t < 5; t++) begin
            cfg_wr(1, 8'hF0, t[2:0], 2'h0);
            rd(3'h3);
            check("trig unsel", trig_rdata_reg, 0);
            rd(3'h7);
            check("trig", trig_rdata_reg, t);
        end
        $display("trigger test done");
    endtask : t_trig

    // Pin 7 is an input, its pad setting is still stored
    task automatic t_pad();
        for (int p = 0; p < 7; p++) begin
            cfg_wr(2, 8'h80, p[2:0], p[1:0]);
            rd(3'h7);
            check("pad", {drive_rdata_reg, pad_rdata_reg}, {p[1:0], p[2:0]});
            check("pad out", {pad_drive_reg[15:14], pad_type_reg[23:21]}, {p[1:0], p[2:0]});
        end
        $display("pad test done");
    endtask : t_pad

    // Pins 4..7 are high-level, 0..3 falling-edge by now
    task automatic t_data();
        int n;
        cfg_wr(0, 8'h0F, 3'h1, 2'h0);
        pin_in = 8'h3C;
        data_wdata = 8'hA5;
        data_wr = 1'b1;
        @(negedge ref_clk);
        data_wr = 1'b0;
        repeat (6) @(negedge ref_clk);
        pin_select_mask = 8'h1E;
        data_rd = 1'b1;
        @(negedge ref_clk);
        data_rd = 1'b0;
        check("data rd", data_rdata_reg, 8'h1C);
        check("sync", pin_sync_reg, 8'h3C);
        check("data out", pin_out_reg[3:0], 4'h5);
        check("level", trig_event_reg, 8'h30);
        pin_in = 8'h00;
        n = 0;
        repeat (10) begin
            @(negedge ref_clk);
            n += trig_event_reg[2];
        end
        check("edge pulses", n, 1);
        $display("data test done");
    endtask : t_data

    initial begin
        {nrst, mode_wr, trig_wr, pad_wr, data_rd, data_wr, pin_index} = 9'h000;
        {mode_wdata, drive_wdata, trig_wdata, pad_wdata} = 10'h000;
        {pin_select_mask, data_wdata, pin_in, periph_out, periph_oe} = 40'h0000000000;
        repeat (8) @(negedge ref_clk);
        nrst = 1'b1;
        t_reset();
        t_mode();
        t_trig();
        t_pad();
        t_data();
        complete_run();
    end

    // Tests need about 120 cycles; this allows 8000
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
endmodule : gpio_port_cfg_tb
